// ### clock_mode_monitor.sv
// assertion checker for the system clock mode control block
`timescale 1ns/1ps
module clock_mode_monitor (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic        halt_req,
    input wire logic        wake_req,
    input wire logic        peripheral_clock_keepalive_bit,
    input wire logic        cpu_clock_en,
    input wire logic        sys_clock_en,
    input wire logic        high_osc_en,
    input wire logic        sys_src_undivided,
    input wire logic        sys_src_low_osc,
    input wire logic [2:0]  sys_div_select
);
    logic       wr_r;
    logic [7:0] wd_r;
    // ------
    // shadow of control register writes
    // ------
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wr_r <= 1'b0;
            wd_r <= 8'h03;
        end else begin
            wr_r <= hsel && hready && htrans[1] && hwrite && (haddr == 32'h0000_0000);
            if (wr_r) begin
                wd_r <= hwdata[7:0];
            end
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // halt only counts while the core runs
    sequence s_halt;
        halt_req && cpu_clock_en;
    endsequence
    sequence s_idle_on;
        s_halt ##0 (wd_r[1] && peripheral_clock_keepalive_bit);
    endsequence
    a_src_follow: assert property (wr_r |-> ##[1:2] (sys_src_undivided == wd_r[0] && sys_div_select == wd_r[7:5])) else $error("clock source outputs do not follow write");
    a_low_src: assert property (sys_src_low_osc == (!sys_src_undivided && sys_div_select[2:1] == 2'h0)) else $error("low source select wrong");
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus not ready or error response");
    a_rsvd_zero: assert property (hrdata[31:8] == 24'h0 && !hrdata[4]) else $error("reserved read bits not zero");
    a_halt_on: assert property (s_idle_on |=> !cpu_clock_en && sys_clock_en) else $error("idle with clock kept wrong");
    a_halt_off: assert property (s_halt ##0 !(wd_r[1] && peripheral_clock_keepalive_bit) |=> !cpu_clock_en && !sys_clock_en) else $error("sleep or clock-off idle wrong");
    a_wake_run: assert property (wake_req && !cpu_clock_en |=> cpu_clock_en && sys_clock_en) else $error("wake did not restart clocks");
    a_halted_hold: assert property (!cpu_clock_en && !wake_req |=> !cpu_clock_en && $stable(sys_clock_en)) else $error("halted state left without wake");
    a_osc_stop: assert property (!sys_clock_en [*2] |-> !high_osc_en) else $error("high oscillator runs while stopped");
endmodule

bind system_clock_mode_control clock_mode_monitor u_mon (.*);

// ### clock_mode_params.svh
// offsets, field positions, reset values and timing counts of the clock mode block
`ifndef CLOCK_MODE_PARAMS_SVH
`define CLOCK_MODE_PARAMS_SVH

// ----------------------------------------------------------------------------
// register map
// ----------------------------------------------------------------------------
`define CTRL_REG_OFFSET      32'h0000_0000
`define CTRL_REG_WIDTH       8

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CLK_SEL_MSB          7
`define CLK_SEL_LSB          5
`define RSVD_BIT             4
`define LOW_READY_BIT        3
`define HIGH_READY_BIT       2
`define IDLE_EN_BIT          1
`define HL_SEL_BIT           0

// ----------------------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------------------
`define CLK_SEL_RESET        3'h0
`define IDLE_EN_RESET        1'h1
`define HL_SEL_RESET         1'h1
`define CLK_SEL_LOW_A        3'h0
`define CLK_SEL_LOW_B        3'h1

// ----------------------------------------------------------------------------
// ready timing, in oscillator clock edges
// ----------------------------------------------------------------------------
`define LOW_READY_EDGES      11'h001
`define HIGH_READY_EDGES     11'h400

`endif

// ### clock_mode_pkg.sv
// types shared by the clock mode block
package clock_mode_pkg;

    // one-hot operating state of the core
    typedef enum logic [3:0] {
        MODE_RUN      = 4'b0001,
        MODE_SLEEP    = 4'b0010,
        MODE_IDLE_OFF = 4'b0100,
        MODE_IDLE_ON  = 4'b1000
    } power_mode_type;

    typedef logic [2:0] clk_sel_type;

endpackage

// ### osc_ready_timer.sv
// counts synchronised oscillator edges and raises a ready flag
`timescale 1ns/1ps
`include "clock_mode_params.svh"

module osc_ready_timer #(
    parameter logic [10:0] EDGE_COUNT = 11'h001
) (
    input  wire logic core_clk,
    input  wire logic resetn,
    input  wire logic osc_in,
    input  wire logic run,
    output logic      ready_r
);

    logic [2:0]  sync_r;
    logic [10:0] count_r;
    logic        osc_rise;

    // ----------------------------------------------------------------------------
    // three-stage capture of the oscillator pin
    // ----------------------------------------------------------------------------
    // stage one is read only by stage two, to contain metastability
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sync_r <= 3'h0;
        end else begin
            sync_r <= {sync_r[1:0], osc_in};
        end
    end

    // rising edge once stages two and three disagree in the rising sense
    assign osc_rise = sync_r[1] & ~sync_r[2];

    // ----------------------------------------------------------------------------
    // edge counter and ready flag
    // ----------------------------------------------------------------------------
    // stopping the oscillator restarts the wait, so each wake counts afresh
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            count_r <= 11'h000;
            ready_r <= 1'b0;
        end else if (!run) begin
            count_r <= 11'h000;
            ready_r <= 1'b0;
        end else if (osc_rise && !ready_r) begin
            count_r <= count_r + 11'h001;
            ready_r <= (count_r + 11'h001) >= EDGE_COUNT;
        end
    end

endmodule

// ### system_clock_mode_control.sv
// system clock source select, oscillator ready flags and halt mode control
//
// Notes on behaviour
// (RULE1) three-bit field picks low or divided clock
// (RULE2) software: clear select, field 000/001 for slow
// (RULE3) select bit high gives undivided high clock
// (RULE4) low ready flag set once oscillator stable
// (RULE5) low ready flag reads low in sleep
// (RULE6) low ready high 1-2 low clocks after wake
// (RULE7) high ready flag: 0 not ready, 1 ready
// (RULE8) high ready low in sleep or idle-off
// (RULE9) high ready after 1024 high oscillator cycles
// (RULE10) idle enable high: halt enters an idle mode
// (RULE11) idle enable low: halt enters sleep
// (RULE12) keep-alive high: cpu stops, system clock runs; code keeps the system clock in idle only, sleep stops both
// (RULE13) keep-alive low: cpu and system clock stop
// (RULE14) ready flags ignore software writes
`timescale 1ns/1ps
`include "clock_mode_params.svh"

module system_clock_mode_control (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    // ahb-lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    // core and oscillators
    input  wire logic        halt_req,
    input  wire logic        wake_req,
    input  wire logic        peripheral_clock_keepalive_bit,
    input  wire logic        low_speed_internal_osc,
    input  wire logic        high_speed_internal_osc,
    // clock tree controls
    output logic             cpu_clock_en,
    output logic             sys_clock_en,
    output logic             high_osc_en,
    output logic             sys_src_undivided,
    output logic             sys_src_low_osc,
    output logic [2:0]       sys_div_select
);

    clock_mode_pkg::clk_sel_type    clock_select_field_r;
    clock_mode_pkg::power_mode_type mode_r;
    clock_mode_pkg::power_mode_type mode_nxt;
    logic        idle_enable_bit_r;
    logic        high_low_select_bit_r;
    logic        low_osc_ready_flag;
    logic        high_osc_ready_flag;
    logic        low_run;
    logic        high_run;
    logic        slow_select;
    logic        wr_pend_r;
    logic        addr_hit;
    logic        take;
    logic [7:0]  reg_view;

    // ----------------------------------------------------------------------------
    // bus slave
    // ----------------------------------------------------------------------------
    // address phase accepted on any active transfer while the bus is ready
    assign take     = hsel & hready & htrans[1];
    assign addr_hit = (haddr == `CTRL_REG_OFFSET);

    // zero wait states, response always okay
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // write is remembered from the address phase, data used in the data phase
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend_r <= 1'b0;
        end else if (hready) begin
            wr_pend_r <= take & hwrite & addr_hit;
        end
    end

    // readable view; reserved bit reads zero, bits above the byte read zero
    assign reg_view = {clock_select_field_r,
                       1'b0,
                       low_osc_ready_flag,
                       high_osc_ready_flag,
                       idle_enable_bit_r,
                       high_low_select_bit_r};

    // read data loaded at the address edge so it stands in the data phase
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= addr_hit ? {24'h00_0000, reg_view} : 32'h0000_0000;
        end
    end

    // ----------------------------------------------------------------------------
    // control fields
    // ----------------------------------------------------------------------------
    // only the writable fields load; flag positions in hwdata are dropped
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            clock_select_field_r  <= `CLK_SEL_RESET;
            idle_enable_bit_r     <= `IDLE_EN_RESET;
            high_low_select_bit_r <= `HL_SEL_RESET;
        end else if (wr_pend_r) begin
            clock_select_field_r  <= hwdata[`CLK_SEL_MSB:`CLK_SEL_LSB]; // [RULE1]
            idle_enable_bit_r     <= hwdata[`IDLE_EN_BIT];
            high_low_select_bit_r <= hwdata[`HL_SEL_BIT]; // [RULE14]
        end
    end

    // ----------------------------------------------------------------------------
    // halt and wake state machine
    // ----------------------------------------------------------------------------
    // halt is only honoured while running; wake only while halted
    always_comb begin
        mode_nxt = mode_r;
        unique case (mode_r)
            clock_mode_pkg::MODE_RUN: begin
                if (halt_req) begin
                    if (!idle_enable_bit_r) begin
                        mode_nxt = clock_mode_pkg::MODE_SLEEP; // [RULE11]
                    end else if (peripheral_clock_keepalive_bit) begin
                        mode_nxt = clock_mode_pkg::MODE_IDLE_ON; // [RULE10]
                    end else begin
                        mode_nxt = clock_mode_pkg::MODE_IDLE_OFF; // [RULE10]
                    end
                end
            end
            clock_mode_pkg::MODE_SLEEP,
            clock_mode_pkg::MODE_IDLE_OFF,
            clock_mode_pkg::MODE_IDLE_ON: begin
                if (wake_req) begin
                    mode_nxt = clock_mode_pkg::MODE_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            mode_r <= clock_mode_pkg::MODE_RUN;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // ----------------------------------------------------------------------------
    // oscillator enables
    // ----------------------------------------------------------------------------
    // slow select lets the high oscillator stop to save power
    assign slow_select = !high_low_select_bit_r &&
                         (clock_select_field_r == `CLK_SEL_LOW_A ||
                          clock_select_field_r == `CLK_SEL_LOW_B); // [RULE2]

    // low oscillator stays up except in sleep, where its flag must read low
    assign low_run  = (mode_r != clock_mode_pkg::MODE_SLEEP); // [RULE5]
    assign high_run = (mode_r == clock_mode_pkg::MODE_RUN ||
                       mode_r == clock_mode_pkg::MODE_IDLE_ON) && !slow_select; // [RULE8]

    // ----------------------------------------------------------------------------
    // ready timers
    // ----------------------------------------------------------------------------
    // one low edge after start gives ready within one to two low clocks
    osc_ready_timer #(
        .EDGE_COUNT (`LOW_READY_EDGES)
    ) u_low_timer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .osc_in   (low_speed_internal_osc),
        .run      (low_run),
        .ready_r  (low_osc_ready_flag) // [RULE4] [RULE6]
    );

    // restarts after reset and after every wake from a stopped state
    osc_ready_timer #(
        .EDGE_COUNT (`HIGH_READY_EDGES)
    ) u_high_timer (
        .core_clk (core_clk),
        .resetn   (resetn),
        .osc_in   (high_speed_internal_osc),
        .run      (high_run),
        .ready_r  (high_osc_ready_flag) // [RULE7] [RULE9]
    );

    // ----------------------------------------------------------------------------
    // clock tree controls
    // ----------------------------------------------------------------------------
    // registered so the clock gates see no glitch from decode logic
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cpu_clock_en <= 1'b1;
            sys_clock_en <= 1'b1;
            high_osc_en  <= 1'b1;
        end else begin
            cpu_clock_en <= (mode_nxt == clock_mode_pkg::MODE_RUN); // [RULE12] [RULE13]
            sys_clock_en <= (mode_nxt == clock_mode_pkg::MODE_RUN ||
                             mode_nxt == clock_mode_pkg::MODE_IDLE_ON); // [RULE12] [RULE13]
            high_osc_en  <= high_run;
        end
    end

    // source select: undivided high, low oscillator, or a divided high tap
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            sys_src_undivided <= 1'b1;
            sys_src_low_osc   <= 1'b0;
            sys_div_select    <= `CLK_SEL_RESET;
        end else begin
            sys_src_undivided <= high_low_select_bit_r; // [RULE3]
            sys_src_low_osc   <= slow_select; // [RULE3]
            sys_div_select    <= clock_select_field_r; // [RULE1]
        end
    end

endmodule

// ### tb_top.sv
// self-checking testbench for the system clock mode control block
`timescale 1ns/1ps
module tb_top;
    logic        core_clk;
    logic        resetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        halt_req;
    logic        wake_req;
    logic        keep_on;
    logic        low_osc;
    logic        high_osc;
    logic        cpu_en;
    logic        sys_en;
    logic        hosc_en;
    logic        undiv;
    logic        low_src;
    logic [2:0]  div_sel;
    logic [31:0] rd;
    int          num_errors = 0;
    int          n_compared = 0;
    int          cyc = 0;

    system_clock_mode_control dut (.core_clk(core_clk), .resetn(resetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .halt_req(halt_req), .wake_req(wake_req), .peripheral_clock_keepalive_bit(keep_on),
        .low_speed_internal_osc(low_osc), .high_speed_internal_osc(high_osc),
        .cpu_clock_en(cpu_en), .sys_clock_en(sys_en), .high_osc_en(hosc_en),
        .sys_src_undivided(undiv), .sys_src_low_osc(low_src), .sys_div_select(div_sel));

    // ------
    // clocks: oscillators run slow enough for the three-flop sync to see edges
    // ------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) cyc <= cyc + 1;
    // high oscillator stands still while the block gates it off
    initial begin
        high_osc = 1'b0;
        forever #40 high_osc = (hosc_en === 1'b1) ? ~high_osc : 1'b0;
    end
    initial begin
        low_osc = 1'b0;
        forever #200 low_osc = ~low_osc;
    end

    task automatic finish_test();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    function automatic logic [31:0] outs();
        return {24'h0, cpu_en, sys_en, hosc_en, undiv, low_src, div_sel};
    endfunction

    // bounded wait for hready at a rising edge
    task automatic wait_rdy();
        int i;
        i = 0;
        do begin
            @(posedge core_clk);
            i++;
        end while (hreadyout !== 1'b1 && i < 50);
        if (hreadyout !== 1'b1) begin
            num_errors++;
            finish_test();
        end
    endtask

    // one single word transfer: address phase, then data phase
    task automatic bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        hsel <= 1'b1;
        wait_rdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_rdy();
        r = hrdata;
        chk("bus response", 32'h0, {31'h0, hresp});
    endtask

    task automatic pulse(input logic wake);
        if (wake) wake_req <= 1'b1;
        else halt_req <= 1'b1;
        @(posedge core_clk);
        halt_req <= 1'b0;
        wake_req <= 1'b0;
        @(posedge core_clk);
    endtask

    // poll a flag; too early or never both count as mismatches
    task automatic wait_bit(input int idx, input int lo, input int hi);
        int t0;
        t0 = cyc;
        do bus(1'b0, 32'h0, 32'h0, rd); while (rd[idx] !== 1'b1 && cyc - t0 < hi);
        chk("ready flag", 32'h1, {31'h0, rd[idx]});
        if (cyc - t0 < lo) chk("ready delay", lo, cyc - t0);
        if (rd[idx] !== 1'b1) finish_test();
    endtask

    task automatic t_reset();
        bus(1'b0, 32'h0, 32'h0, rd);
        chk("control reg", 32'h03, rd);
        chk("clock outputs", 32'hF0, outs());
        wait_bit(3, 0, 120);
        wait_bit(2, 8000, 8300);
    endtask

    task automatic t_select();
        for (int f = 0; f < 8; f++) begin
            bus(1'b1, 32'h0, {24'h0, f[2:0], 5'h02}, rd);
            repeat (2) @(posedge core_clk);
            chk("clock select", {24'h0, 2'b11, f >= 2, 1'b0, f < 2, f[2:0]}, outs());
        end
        bus(1'b1, 32'h0, 32'hFF, rd);
        bus(1'b0, 32'h0, 32'h0, rd);
        chk("read-only flags", 32'hEB, rd);
        chk("undivided select", 32'hF7, outs());
        bus(1'b1, 32'h4, 32'h0, rd);
        bus(1'b0, 32'h4, 32'h0, rd);
        chk("unmapped read", 32'h0, rd);
        bus(1'b0, 32'h0, 32'h0, rd);
        chk("control reg", 32'hEB, rd);
        wait_bit(2, 8000, 8300);
    endtask

    // sleep, clock-off idle and clock-on idle, each followed by a wake
    task automatic t_modes();
        for (int m = 0; m < 4; m++) begin
            bus(1'b1, 32'h0, {30'h0, m[1], 1'b1}, rd);
            keep_on <= m[0];
            pulse(1'b0);
            chk("halt enables", {31'h0, m == 3}, {30'h0, cpu_en, sys_en});
            bus(1'b0, 32'h0, 32'h0, rd);
            chk("halted flags", {28'h0, m[1], m == 3, 2'h0}, {28'h0, rd[3:2], 2'h0});
            pulse(1'b1);
            chk("wake enables", 32'h3, {30'h0, cpu_en, sys_en});
            wait_bit(3, 0, 90);
            wait_bit(2, (m == 3) ? 0 : 8000, 8300);
        end
    endtask

    initial begin
        resetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        halt_req = 1'b0;
        wake_req = 1'b0;
        keep_on = 1'b0;
        repeat (5) @(posedge core_clk);
        resetn <= 1'b1;
        @(posedge core_clk);
        t_reset();
        t_select();
        t_modes();
        finish_test();
    end
endmodule
